// ==== bench/drb_core_checker.sv ====
// port assertions for the bank, burst and refresh block
`timescale 1ns/10ps
`include "drb_regs.svh"
module drb_core_checker
  import drb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire drb_cmd_s cmd,
  input wire logic rd_burst,
  input wire logic rd_chop,
  input wire logic ref_busy,
  input wire logic [14:0] ref_row
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // pclk cycles since the pins last showed a refresh command
  logic [4:0] since_ref;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      since_ref <= 5'h1f;
    else if ({cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} == `DRB_OP_REF)
      since_ref <= 5'h00;
    else if (since_ref != 5'h1f)
      since_ref <= since_ref + 5'h01;
  end
  AST_RDY_ANSWER: assert property ($rose(penable) && psel |=> pready)
    else $error("pready missing one cycle after access phase");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_UNMAPPED: assert property (pready && paddr > 12'h00c |-> pslverr)
    else $error("no pslverr on unmapped address");
  AST_PRDATA_HOLD: assert property ($changed(prdata) |-> pready)
    else $error("prdata moved outside an answer");
  AST_CHOP_IN_BURST: assert property (rd_chop |-> rd_burst)
    else $error("rd_chop outside a burst");
  AST_BURST_MIN: assert property ($rose(rd_burst) |-> rd_burst[*8])
    else $error("read burst too short");
  AST_ROW_STEP: assert property ($changed(ref_row) |->
    ref_row == $past(ref_row) + 15'h0001)
    else $error("refresh row did not step by one");
  AST_REF_CAUSE: assert property ($rose(ref_busy) |->
    since_ref < 5'h10)
    else $error("refresh started without a refresh command");
  AST_BUSY_MIN: assert property ($rose(ref_busy) |-> ref_busy[*8])
    else $error("refresh busy too short");
endmodule // drb_core_checker
bind drb_core drb_core_checker u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .cmd, .rd_burst, .rd_chop,
  .ref_busy, .ref_row);

// ==== bench/drb_core_tb_top.sv ====
// self-checking bench for the bank, burst and refresh block
`timescale 1ns/10ps
`include "drb_regs.svh"
module drb_core_tb_top
  import drb_pkg::*;
;
  typedef struct packed {logic rd; logic [31:0] d; logic e;} drb_exp_s;
  localparam logic [31:0] CFG = {4'h0, 10'h014, 8'h08, 5'h04, 5'h05};
  localparam int RL = 4 + 5;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic wr_viol = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [11:0] ra;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rv;
  logic [14:0] row;
  logic [14:0] ref_row;
  logic pready, pslverr, ck, rd_burst, rd_chop, ref_busy;
  drb_cmd_s cmd;
  drb_exp_s x;
  int ck_cnt, cmd_edge;
  int n_errors = 0;
  int tests_run = 0;
  integer seed = 32'hcf019fdf;
  drb_exp_s apb_q[$];
  int lat_q[$];
  logic chop_q[$];
  always #12.5 pclk = ~pclk;
  drb_core u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ck, .cmd, .wr_viol, .rd_burst,
    .rd_chop, .ref_busy, .ref_row);
  drb_ctl_model u_ctl (.pclk, .ck, .cmd, .ck_cnt, .cmd_edge);
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hang;
    n_errors++;
    report_and_stop();
  endtask
  task automatic wait_ref;
    int k;
    k = 0;
    while (ref_busy !== 1'b0 && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 2000) hang();
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] exp, input logic e);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    apb_q.push_back({~w, exp, e});
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) hang();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [2:0] b, input logic [14:0] a, input int g);
    u_ctl.go(`DRB_OP_RD, b, a, 0);
    lat_q.push_back(cmd_edge + RL);
    chop_q.push_back(~a[`DRB_BL_BIT]);
    repeat (g) @(negedge ck);
    @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1 && apb_q.size() > 0) begin
      x = apb_q.pop_front();
      chk("pslverr", x.e, pslverr);
      if (x.rd) chk("prdata", x.d, prdata);
    end
  end
  always @(posedge rd_burst) begin
    #1;
    if (lat_q.size() == 0) chk("stray burst", 0, 1);
    else begin
      chk("read latency", lat_q.pop_front(), ck_cnt);
      chk("rd_chop", chop_q.pop_front(), rd_chop);
    end
  end
  initial begin
    #2000000;
    hang();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `DRB_CFG_OFS, 0, {4'h0, `DRB_CFG_RST}, 0);
    apb(0, `DRB_STAT_OFS, 0, 0, 0);
    apb(0, `DRB_ERR_OFS, 0, 0, 0);
    apb(0, `DRB_CNT_OFS, 0, 0, 0);
    ra = {2'b01, 10'($random(seed))};
    rv = $random(seed);
    row = 15'($random(seed));
    apb(1, ra, rv, 0, 1);
    apb(0, ra, 0, 0, 1);
    apb(1, `DRB_STAT_OFS, rv, 0, 0);
    apb(1, `DRB_CFG_OFS, CFG, 0, 0);
    apb(0, `DRB_CFG_OFS, 0, CFG, 0);
    $display("register test done");
    u_ctl.go(`DRB_OP_ACT, 3'h1, row, 1);
    u_ctl.go(`DRB_OP_ACT, 3'h2, ~row, 1);
    apb(0, `DRB_STAT_OFS, 0, 32'h6, 0);
    rd(3'h1, 15'h1000, 14);
    rd(3'h2, 15'h0400, 4);
    rd(3'h1, 15'h0000, 14);
    apb(0, `DRB_STAT_OFS, 0, 32'h2, 0);
    $display("burst test done");
    wr_viol <= 1'b1;
    u_ctl.go(`DRB_OP_WR, 3'h1, 15'h1000, 2);
    wr_viol <= 1'b0;
    rd(3'h1, 15'h1000, 14);
    u_ctl.go(`DRB_OP_PRE, 3'h1, 15'h0000, 4);
    u_ctl.go(`DRB_OP_PRE, 3'h1, 15'h0000, 2);
    u_ctl.go(`DRB_OP_ACT, 3'h1, row, 10);
    apb(0, `DRB_STAT_OFS, 0, 32'h0, 0);
    u_ctl.go(`DRB_OP_PRE, 3'h0, 15'h0400, 10);
    $display("precharge test done");
    u_ctl.go(`DRB_OP_REF, 3'($random(seed)), 15'($random(seed)), 0);
    u_ctl.go(`DRB_OP_ACT, 3'h3, row, 0);
    chk("ref_busy", 1, ref_busy);
    wait_ref();
    // a second refresh pulled in early is still taken and counted
    u_ctl.go(`DRB_OP_REF, 3'h0, row, 0);
    chk("ref_busy", 1, ref_busy);
    wait_ref();
    chk("ref_row", 2, ref_row);
    apb(0, `DRB_STAT_OFS, 0, 32'h400, 0);
    apb(0, `DRB_CNT_OFS, 0, 32'h00020001, 0);
    apb(0, `DRB_ERR_OFS, 0, 32'h1a, 0);
    apb(1, `DRB_ERR_OFS, 32'h3f, 0, 0);
    apb(0, `DRB_ERR_OFS, 0, 0, 0);
    chk("bursts left", 0, lat_q.size());
    // block under test is reset after the deliberate violations
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `DRB_CNT_OFS, 0, 0, 0);
    apb(0, `DRB_CFG_OFS, 0, {4'h0, `DRB_CFG_RST}, 0);
    $display("refresh test done");
    report_and_stop();
  end
endmodule // drb_core_tb_top

// ==== bench/drb_ctl_model.sv ====
// controller side: free running link clock and command pins
`timescale 1ns/10ps
module drb_ctl_model
  import drb_pkg::*;
(
  input wire logic pclk,
  output logic ck,
  output drb_cmd_s cmd,
  output int ck_cnt,
  output int cmd_edge
);
  initial begin
    ck = 1'b0;
    ck_cnt = 0;
    cmd_edge = 0;
    cmd = '1;
    #37;
    forever #100 ck = ~ck;
  end
  always @(posedge ck) ck_cnt++;
  // one command per ck cycle, order and spacing set by caller
  task automatic go(input logic [3:0] op, input logic [2:0] b,
    input logic [14:0] a, input int gap);
    @(negedge ck);
    @(posedge pclk);
    cmd_edge = ck_cnt + 1;
    cmd <= {op, b, a};
    @(negedge ck);
    @(posedge pclk);
    // deselected bus shows all command lines high and inverted bank and address lines, never a stale copy
    cmd <= {4'hf, ~b, ~a};
    repeat (gap) @(negedge ck);
    @(posedge pclk);
  endtask
endmodule // drb_ctl_model

// ==== design/drb_core.sv ====
// bank row state, burst selection, read latency and refresh engine
//
// Overview of operation
// - ACTIVE opens the row on A0-A14 in the bank on BA0-BA2.
// - PRECHARGE closes one or all banks; no ACTIVE until tRP passes.
// - during auto precharge, accesses to other banks are still accepted.
// - PRECHARGE to an idle or precharging bank is accepted.
// - the precharge period counts from the latest PRECHARGE to a bank.
// - A12 low picks a chopped 4-beat burst, high an 8-beat burst.
// - A12 only controls burst length; auto precharge is independent.
// - read data starts after additive plus CAS latency.
// - data setup/hold violations only corrupt that write's data.
// - strobe timing violations only corrupt the addressed location.
// - CS#, RAS#, CAS# low with WE# high decodes a refresh.
// - refresh rows come from an internal counter, not the address bus.
// - after refresh all banks idle; only NOP/DES until tRFC passes.
// - up to eight refreshes may be pulled in for credit; here any refresh outside tRFC is taken and counted, with no limit.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "drb_regs.svh"
module drb_core
  import drb_pkg::*;
#(
  parameter int PIPE_DEPTH = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ck,
  input wire drb_cmd_s cmd,
  input wire logic wr_viol,
  output logic rd_burst,
  output logic rd_chop,
  output logic ref_busy,
  output logic [14:0] ref_row
);

  // pin synchronisers; the link clock is sampled like any pin
  logic ck_meta, ck_sync, ck_prev;
  drb_cmd_s cmd_meta, cmd_sync;
  logic viol_meta, viol_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_meta <= 1'b0;
      ck_sync <= 1'b0;
      ck_prev <= 1'b0;
      cmd_meta <= '1;
      cmd_sync <= '1;
      viol_meta <= 1'b0;
      viol_sync <= 1'b0;
    end else begin
      ck_meta <= ck;
      ck_sync <= ck_meta;
      ck_prev <= ck_sync;
      cmd_meta <= cmd;
      cmd_sync <= cmd_meta;
      viol_meta <= wr_viol;
      viol_sync <= viol_meta;
    end
  end

  // command and pins go through equal delay, so they line up with the edge
  logic ck_rise;
  assign ck_rise = ck_sync & ~ck_prev;

  drb_cfg_s cfg;
  drb_ref_e ref_state;
  logic [3:0] op;
  logic cmd_live, ref_idle;
  logic is_act, is_pre, is_rd, is_wr, is_ref;
  logic pre_all, auto_pre, sel_open, sel_busy;
  logic act_ok, rw_ok, ref_go;
  logic [7:0] bank_open, bank_busy;

  assign op = {cmd_sync.cs_n, cmd_sync.ras_n, cmd_sync.cas_n,
               cmd_sync.we_n};
  assign ref_idle = (ref_state == REF_IDLE);
  // deselect and NOP are the only commands that pass during tRFC
  assign cmd_live = ck_rise & ~cmd_sync.cs_n & (op != `DRB_OP_NOP);
  assign is_act = cmd_live & ref_idle & (op == `DRB_OP_ACT);
  assign is_pre = cmd_live & ref_idle & (op == `DRB_OP_PRE);
  assign is_rd = cmd_live & ref_idle & (op == `DRB_OP_RD);
  assign is_wr = cmd_live & ref_idle & (op == `DRB_OP_WR);
  assign is_ref = cmd_live & ref_idle & (op == `DRB_OP_REF);
  assign pre_all = cmd_sync.addr[`DRB_AP_BIT];
  assign auto_pre = cmd_sync.addr[`DRB_AP_BIT];
  assign sel_open = bank_open[cmd_sync.ba];
  assign sel_busy = bank_busy[cmd_sync.ba];
  // ACTIVE into an open or still precharging bank is dropped
  assign act_ok = is_act & ~sel_open & ~sel_busy;
  // column access only to an activated bank; other banks stay free
  assign rw_ok = (is_rd | is_wr) & sel_open;
  // taken whenever idle, so a pulled-in refresh still counts
  assign ref_go = is_ref;

  // per-bank row state and precharge timer
  logic [14:0] bank_row [8];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_bank
      logic [7:0] trp_cnt;
      logic hit;
      logic bank_row_open;
      assign hit = (cmd_sync.ba == 3'(gi));
      assign bank_open[gi] = bank_row_open;
      assign bank_busy[gi] = (trp_cnt != 8'h00);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bank_row_open <= 1'b0;
          bank_row[gi] <= 15'h0000;
          trp_cnt <= 8'h00;
        end else if (ref_go) begin
          bank_row_open <= 1'b0;
          trp_cnt <= 8'h00;
        end else if (is_pre & (hit | pre_all)) begin
          // restart on every precharge, idle or not
          bank_row_open <= 1'b0;
          trp_cnt <= cfg.trp;
        end else if (act_ok & hit) begin
          bank_row_open <= 1'b1;
          bank_row[gi] <= cmd_sync.addr;
        end else if (rw_ok & hit & auto_pre) begin
          // auto precharge closes at once; the burst pipe runs on alone
          bank_row_open <= 1'b0;
          trp_cnt <= cfg.trp;
        end else if (ck_rise & (trp_cnt != 8'h00)) begin
          trp_cnt <= trp_cnt - 8'h01;
        end
      end
    end
  endgenerate

  // read latency pipe: one slot per CK cycle, launched at AL+CL
  logic [5:0] rl;
  logic [PIPE_DEPTH-1:0] pipe_v, pipe_c, slot;
  logic [2:0] burst_cnt;
  assign rl = 6'(cfg.al) + 6'(cfg.cl);
  assign slot = (rl == 6'h00) ? PIPE_DEPTH'(1) :
                (PIPE_DEPTH'(1) << (rl - 6'h01));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_v <= '0;
      pipe_c <= '0;
    end else if (ck_rise) begin
      pipe_v <= (pipe_v >> 1) | ((is_rd & rw_ok) ? slot : '0);
      // A12 low means chop; it never reaches the column path
      pipe_c <= (pipe_c >> 1) |
                ((is_rd & rw_ok & ~cmd_sync.addr[`DRB_BL_BIT]) ?
                 slot : '0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_cnt <= 3'h0;
      rd_burst <= 1'b0;
      rd_chop <= 1'b0;
    end else if (ck_rise) begin
      if (pipe_v[0]) begin
        // a seamless follow-on read simply reloads the length
        burst_cnt <= pipe_c[0] ? `DRB_BC4_CK : `DRB_BL8_CK;
        rd_burst <= 1'b1;
        rd_chop <= pipe_c[0];
      end else if (burst_cnt > 3'h1) begin
        burst_cnt <= burst_cnt - 3'h1;
      end else begin
        burst_cnt <= 3'h0;
        rd_burst <= 1'b0;
        rd_chop <= 1'b0;
      end
    end
  end

  // refresh engine
  logic [9:0] trfc_cnt;
  logic [15:0] ref_count;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_state <= REF_IDLE;
      ref_busy <= 1'b0;
      trfc_cnt <= 10'h000;
      ref_row <= 15'h0000;
      ref_count <= 16'h0000;
    end else begin
      case (ref_state)
        REF_IDLE: begin
          if (ref_go) begin
            // address bus ignored; rows come from our own counter
            ref_row <= ref_row + 15'h0001;
            ref_count <= ref_count + 16'h0001;
            trfc_cnt <= cfg.trfc;
            ref_state <= REF_BUSY;
            ref_busy <= 1'b1;
          end
        end
        REF_BUSY: begin
          if (ck_rise) begin
            if (trfc_cnt <= 10'h001) begin
              trfc_cnt <= 10'h000;
              ref_state <= REF_IDLE;
              ref_busy <= 1'b0;
            end else begin
              trfc_cnt <= trfc_cnt - 10'h001;
            end
          end
        end
        default: begin
          ref_state <= REF_IDLE;
          ref_busy <= 1'b0;
        end
      endcase
    end
  end

  // a strobe violation only flags and counts; state is untouched
  logic [15:0] viol_count;
  logic wr_bad;
  assign wr_bad = is_wr & rw_ok & viol_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      viol_count <= 16'h0000;
    end else if (wr_bad) begin
      viol_count <= viol_count + 16'h0001;
    end
  end

  // error sources for software
  logic [`DRB_ERR_W-1:0] err, err_set, err_clr;
  always_comb begin
    err_set = '0;
    err_set[`DRB_ERR_ACT_OPEN] = is_act & sel_open;
    err_set[`DRB_ERR_ACT_TRP] = is_act & sel_busy;
    err_set[`DRB_ERR_IDLE_RW] = (is_rd | is_wr) & ~sel_open;
    err_set[`DRB_ERR_TRFC] = cmd_live & ~ref_idle;
    err_set[`DRB_ERR_WR_VIOL] = wr_bad;
    err_set[`DRB_ERR_REF_OPEN] = is_ref & (|bank_open);
  end

  // apb slave: one wait state, write lands on the completing edge
  logic acc, wr_done, hit_cfg, hit_stat, hit_err, hit_cnt, mapped;
  assign acc = psel & penable;
  assign hit_cfg = (paddr == `DRB_CFG_OFS);
  assign hit_stat = (paddr == `DRB_STAT_OFS);
  assign hit_err = (paddr == `DRB_ERR_OFS);
  assign hit_cnt = (paddr == `DRB_CNT_OFS);
  assign mapped = hit_cfg | hit_stat | hit_err | hit_cnt;
  assign wr_done = acc & pready & pwrite & mapped;
  assign err_clr = (wr_done & hit_err) ? pwdata[`DRB_ERR_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= drb_cfg_s'(`DRB_CFG_RST);
    end else if (wr_done & hit_cfg) begin
      cfg <= drb_cfg_s'(pwdata[27:0]);
    end
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= '0;
    end else begin
      err <= (err & ~err_clr) | err_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      if (acc & ~pready & ~pwrite) begin
        prdata <= 32'h0000_0000;
        if (hit_cfg) begin
          prdata <= {4'h0, cfg};
        end
        if (hit_stat) begin
          prdata <= {8'h00, ref_row, ref_busy, bank_open};
        end
        if (hit_err) begin
          prdata <= {{(32-`DRB_ERR_W){1'b0}}, err};
        end
        if (hit_cnt) begin
          prdata <= {ref_count, viol_count};
        end
      end
    end
  end

endmodule // drb_core

// ==== design/drb_pkg.sv ====
// types shared by the bank, burst and refresh logic
package drb_pkg;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [14:0] addr;
  } drb_cmd_s;
  typedef struct packed {
    logic [9:0] trfc;
    logic [7:0] trp;
    logic [4:0] al;
    logic [4:0] cl;
  } drb_cfg_s;
  typedef enum logic [1:0] {
    REF_IDLE = 2'b01,
    REF_BUSY = 2'b10
  } drb_ref_e;
endpackage

// ==== design/drb_regs.svh ====
// register map, field positions, reset values and command codes
`ifndef DRB_REGS_SVH
`define DRB_REGS_SVH
`define DRB_CFG_OFS 12'h000
`define DRB_STAT_OFS 12'h004
`define DRB_ERR_OFS 12'h008
`define DRB_CNT_OFS 12'h00c
`define DRB_CFG_RST 28'h2802c05
`define DRB_ERR_W 6
`define DRB_ERR_ACT_OPEN 0
`define DRB_ERR_ACT_TRP 1
`define DRB_ERR_IDLE_RW 2
`define DRB_ERR_TRFC 3
`define DRB_ERR_WR_VIOL 4
`define DRB_ERR_REF_OPEN 5
`define DRB_OP_REF 4'h1
`define DRB_OP_PRE 4'h2
`define DRB_OP_ACT 4'h3
`define DRB_OP_WR 4'h4
`define DRB_OP_RD 4'h5
`define DRB_OP_NOP 4'h7
`define DRB_AP_BIT 10
`define DRB_BL_BIT 12
`define DRB_BL8_CK 3'h4
`define DRB_BC4_CK 3'h2
`endif
